// [rtl/spc_record_sum.sv]
// Record parser and checksum generator for serial programming mode
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"

module spc_record_sum (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CMD_START,
  input wire logic [7:0] CMD,
  input wire logic [15:0] RANGE_LO,
  input wire logic [15:0] RANGE_HI,
  input wire logic OVERWRITE,
  input wire spc_pkg::spc_rx_t RX,
  input wire spc_pkg::spc_xfer_t XFER,
  input wire logic [7:0] MEM_RDATA,
  input wire logic TX_READY,
  output spc_pkg::spc_tx_t TX,
  output spc_pkg::spc_wr_t WR,
  output spc_pkg::spc_mem_t MEM,
  output logic BUSY,
  output logic LOCKED
);

  spc_pkg::spc_regs_t r;
  spc_pkg::spc_regs_t next_r;
  logic rx_bad;
  logic rx_good;
  logic [7:0] rx_d;
  logic [7:0] next_cnt;
  logic [15:0] sum_add;
  logic [7:0] rsum_add;
  logic [19:0] wr_base;

  // Helper terms for the receive path and the running sums
  assign rx_bad = RX.valid & (RX.frm_err | RX.ovr_err);
  assign rx_good = RX.valid & ~RX.frm_err & ~RX.ovr_err;
  assign rx_d = RX.data;
  assign next_cnt = r.cnt + 8'h01;
  assign rsum_add = r.rsum + rx_d;
  assign sum_add = r.csum + {8'h00, rx_d};
  // Extended segment shifts by one nibble, offset and index add on top
  assign wr_base = {r.seg, 4'h0} + {4'h0, r.ofs} + {12'h000, r.cnt};

  // Next-state logic for the whole block
  always_comb
  begin
    next_r = r;
    next_r.wr.valid = 1'b0;
    next_r.mem.rd = 1'b0;
    next_r.rd_d = r.mem.rd;
    case (r.state)
      spc_pkg::ST_READY:
      begin
        if (CMD_START)
        begin
          next_r.csum = 16'h0000;
          next_r.cnt = 8'h00;
          next_r.issued = 1'b0;
          next_r.after_write = 1'b0;
          next_r.seg = 16'h0000;
          next_r.seg_over = 1'b0;
          case (CMD)
            `SPC_CMD_WRITE, `SPC_CMD_RAM:
            begin
              next_r.is_ram = (CMD == `SPC_CMD_RAM);
              next_r.state = spc_pkg::ST_HUNT;
            end
            `SPC_CMD_ERASE, `SPC_CMD_READ:
            begin
              next_r.mem.addr = RANGE_LO;
              next_r.sweep_end = RANGE_HI;
              next_r.state = spc_pkg::ST_SWEEP;
            end
            `SPC_CMD_SUM:
            begin
              next_r.mem.addr = `SPC_FLASH_LO;
              next_r.sweep_end = `SPC_FLASH_HI;
              next_r.state = spc_pkg::ST_SWEEP;
            end
            `SPC_CMD_ID:
            begin
              next_r.last = `SPC_ID_LAST;
              next_r.state = spc_pkg::ST_XFER;
            end
            `SPC_CMD_STATUS:
            begin
              next_r.last = `SPC_STATUS_LAST;
              next_r.state = spc_pkg::ST_XFER;
            end
            default:
            begin
              // Unknown command: report and lock up
              next_r.rep = {3{`SPC_ERR_CMD}};
              next_r.left = `SPC_REPLY_THREE;
              next_r.tx.valid = 1'b1;
              next_r.fatal = 1'b1;
              next_r.state = spc_pkg::ST_REPLY;
            end
          endcase
        end
        else if (rx_bad)
        begin
          // Framing takes priority when both flags are raised
          next_r.rep = RX.frm_err ? {3{`SPC_ERR_FRAME}} : {3{`SPC_ERR_OVERRUN}};
          next_r.left = `SPC_REPLY_THREE;
          next_r.tx.valid = 1'b1;
          next_r.fatal = 1'b1;
          next_r.state = spc_pkg::ST_REPLY;
        end
      end
      spc_pkg::ST_HUNT, spc_pkg::ST_LEN, spc_pkg::ST_OFSH, spc_pkg::ST_OFSL,
      spc_pkg::ST_TYPE, spc_pkg::ST_DATA, spc_pkg::ST_CKS:
      begin
        if (rx_bad)
        begin
          next_r.state = spc_pkg::ST_DEAD;
        end
        else if (rx_good)
        begin
          case (r.state)
            spc_pkg::ST_HUNT:
            begin
              // Anything but the start mark is dropped here
              if (rx_d == `SPC_START_MARK)
              begin
                next_r.rsum = 8'h00;
                next_r.state = spc_pkg::ST_LEN;
              end
            end
            spc_pkg::ST_LEN:
            begin
              next_r.len = rx_d;
              next_r.rsum = rsum_add;
              next_r.state = spc_pkg::ST_OFSH;
            end
            spc_pkg::ST_OFSH:
            begin
              next_r.ofs[15:8] = rx_d;
              next_r.rsum = rsum_add;
              next_r.state = spc_pkg::ST_OFSL;
            end
            spc_pkg::ST_OFSL:
            begin
              next_r.ofs[7:0] = rx_d;
              next_r.rsum = rsum_add;
              next_r.state = spc_pkg::ST_TYPE;
            end
            spc_pkg::ST_TYPE:
            begin
              next_r.typ = rx_d;
              next_r.rsum = rsum_add;
              next_r.cnt = 8'h00;
              next_r.state = (r.len == 8'h00) ? spc_pkg::ST_CKS : spc_pkg::ST_DATA;
              if ((rx_d != `SPC_TYPE_DATA) && (rx_d != `SPC_TYPE_END) &&
                  (rx_d != `SPC_TYPE_EXT))
              begin
                next_r.state = spc_pkg::ST_DEAD;
              end
              if ((rx_d == `SPC_TYPE_EXT) &&
                  ((r.len != `SPC_EXT_LEN) || (r.ofs != 16'h0000)))
              begin
                next_r.state = spc_pkg::ST_DEAD;
              end
              if ((rx_d == `SPC_TYPE_END) && (r.len != `SPC_END_LEN))
              begin
                next_r.state = spc_pkg::ST_DEAD;
              end
              if ((rx_d == `SPC_TYPE_DATA) && r.seg_over)
              begin
                next_r.state = spc_pkg::ST_DEAD;
              end
            end
            spc_pkg::ST_DATA:
            begin
              next_r.rsum = rsum_add;
              next_r.cnt = next_cnt;
              if (r.typ == `SPC_TYPE_DATA)
              begin
                // Only payload reaches the returned sum
                next_r.csum = sum_add;
                next_r.wr.valid = 1'b1;
                next_r.wr.ram = r.is_ram;
                next_r.wr.addr = wr_base;
                next_r.wr.data = rx_d;
              end
              else if (r.cnt == 8'h00)
              begin
                next_r.seg_new[15:8] = rx_d;
              end
              else
              begin
                next_r.seg_new[7:0] = rx_d;
              end
              if (next_cnt == r.len)
              begin
                next_r.state = spc_pkg::ST_CKS;
              end
            end
            spc_pkg::ST_CKS:
            begin
              if (rsum_add != 8'h00)
              begin
                next_r.state = spc_pkg::ST_DEAD;
              end
              else if (r.typ == `SPC_TYPE_EXT)
              begin
                // Segment takes effect only once its record checks out
                next_r.seg = r.seg_new;
                next_r.seg_over = (r.seg_new > `SPC_SEG_LIMIT);
                next_r.state = spc_pkg::ST_HUNT;
              end
              else if (r.typ == `SPC_TYPE_DATA)
              begin
                next_r.state = spc_pkg::ST_HUNT;
              end
              else if (r.is_ram)
              begin
                next_r.rep = {r.csum, 8'h00};
                next_r.left = `SPC_REPLY_TWO;
                next_r.tx.valid = 1'b1;
                next_r.state = spc_pkg::ST_REPLY;
              end
              else
              begin
                // Partial writes still report the whole array
                next_r.csum = 16'h0000;
                next_r.mem.addr = `SPC_FLASH_LO;
                next_r.sweep_end = `SPC_FLASH_HI;
                next_r.issued = 1'b0;
                next_r.after_write = 1'b1;
                next_r.state = spc_pkg::ST_SWEEP;
              end
            end
            default:
            begin
              next_r.state = spc_pkg::ST_DEAD;
            end
          endcase
        end
      end
      spc_pkg::ST_SWEEP:
      begin
        // One read per cycle, data arrives one cycle after the request
        if (!r.issued)
        begin
          next_r.mem.rd = 1'b1;
          if (r.mem.rd)
          begin
            next_r.mem.addr = r.mem.addr + 16'h0001;
          end
          if ((r.mem.rd && (r.mem.addr + 16'h0001 == r.sweep_end)) ||
              (!r.mem.rd && (r.mem.addr == r.sweep_end)))
          begin
            next_r.issued = 1'b1;
          end
        end
        if (r.rd_d)
        begin
          next_r.csum = r.csum + {8'h00, MEM_RDATA};
        end
        if (r.issued && !r.mem.rd && r.rd_d)
        begin
          next_r.tx.valid = 1'b1;
          next_r.state = spc_pkg::ST_REPLY;
          if (r.after_write)
          begin
            next_r.rep = {7'h00, OVERWRITE, next_r.csum};
            next_r.left = `SPC_REPLY_THREE;
          end
          else
          begin
            next_r.rep = {next_r.csum, 8'h00};
            next_r.left = `SPC_REPLY_TWO;
          end
        end
      end
      spc_pkg::ST_XFER:
      begin
        if (XFER.valid)
        begin
          next_r.cnt = next_cnt;
          if ((next_cnt >= `SPC_XFER_FIRST) && (next_cnt <= r.last))
          begin
            next_r.csum = r.csum + {8'h00, XFER.data};
          end
          if (next_cnt == r.last)
          begin
            next_r.rep = {next_r.csum, 8'h00};
            next_r.left = `SPC_REPLY_TWO;
            next_r.tx.valid = 1'b1;
            next_r.state = spc_pkg::ST_REPLY;
          end
        end
      end
      spc_pkg::ST_REPLY:
      begin
        // High byte leaves first
        if (TX_READY && r.tx.valid)
        begin
          next_r.rep = {r.rep[15:0], 8'h00};
          next_r.left = r.left - 2'h1;
          if (r.left == 2'h1)
          begin
            next_r.tx.valid = 1'b0;
            next_r.state = r.fatal ? spc_pkg::ST_DEAD : spc_pkg::ST_READY;
          end
        end
      end
      spc_pkg::ST_DEAD:
      begin
        // Only the reset pin leaves this state
        next_r.state = spc_pkg::ST_DEAD;
      end
      default:
      begin
        next_r.state = spc_pkg::ST_DEAD;
      end
    endcase
    next_r.tx.data = next_r.rep[23:16];
  end

  // State register
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // All data outputs straight from flip-flops
  assign TX = r.tx;
  assign WR = r.wr;
  assign MEM = r.mem;
  assign BUSY = (r.state != spc_pkg::ST_READY) && (r.state != spc_pkg::ST_DEAD);
  assign LOCKED = (r.state == spc_pkg::ST_DEAD);

endmodule

`default_nettype wire

// [rtl/spc_cfg.svh]
// Constants for the serial-programming record parser and checksum block
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// Operation command codes
`define SPC_CMD_ERASE 8'hF0
`define SPC_CMD_WRITE 8'h30
`define SPC_CMD_SUM 8'h90
`define SPC_CMD_READ 8'h40
`define SPC_CMD_RAM 8'h60
`define SPC_CMD_ID 8'hC0
`define SPC_CMD_STATUS 8'hC3

// Record framing
`define SPC_START_MARK 8'h3A
`define SPC_TYPE_DATA 8'h00
`define SPC_TYPE_END 8'h01
`define SPC_TYPE_EXT 8'h02
`define SPC_EXT_LEN 8'h02
`define SPC_END_LEN 8'h00
`define SPC_SEG_LIMIT 16'h2000

// Error report codes
`define SPC_ERR_CMD 8'h63
`define SPC_ERR_FRAME 8'hA1
`define SPC_ERR_OVERRUN 8'hA3

// Flash array bounds
`define SPC_FLASH_LO 16'h8000
`define SPC_FLASH_HI 16'hFFFF

// Byte windows of transferred data that are summed
`define SPC_XFER_FIRST 8'h09
`define SPC_ID_LAST 8'h12
`define SPC_STATUS_LAST 8'h0C

// Reply lengths in bytes
`define SPC_REPLY_TWO 2'h2
`define SPC_REPLY_THREE 2'h3

`endif

// [rtl/spc_pkg.sv]
// Types shared by the record parser and checksum block
package spc_pkg;

  // Received byte from the serial receiver, with its error flags
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic frm_err;
    logic ovr_err;
  } spc_rx_t;

  // Byte seen on the transfer path for identification and status output
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spc_xfer_t;

  // Payload byte handed to the flash or RAM writer
  typedef struct packed {
    logic valid;
    logic ram;
    logic [19:0] addr;
    logic [7:0] data;
  } spc_wr_t;

  // Flash read request for checksum sweeps
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } spc_mem_t;

  // Reply byte toward the controller
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spc_tx_t;

  typedef enum logic [3:0] {
    ST_READY,
    ST_HUNT,
    ST_LEN,
    ST_OFSH,
    ST_OFSL,
    ST_TYPE,
    ST_DATA,
    ST_CKS,
    ST_SWEEP,
    ST_XFER,
    ST_REPLY,
    ST_DEAD
  } spc_state_t;

  // Whole state of the block
  typedef struct packed {
    spc_state_t state;
    logic is_ram;
    logic after_write;
    logic fatal;
    logic [7:0] len;
    logic [15:0] ofs;
    logic [7:0] typ;
    logic [7:0] cnt;
    logic [7:0] last;
    logic [7:0] rsum;
    logic [15:0] seg;
    logic [15:0] seg_new;
    logic seg_over;
    logic [15:0] csum;
    logic [15:0] sweep_end;
    logic issued;
    logic rd_d;
    logic [23:0] rep;
    logic [1:0] left;
    spc_tx_t tx;
    spc_wr_t wr;
    spc_mem_t mem;
  } spc_regs_t;

endpackage

// [tb/spc_assertions.sv]
// Port-level assertions for the record parser and checksum block
`timescale 1ns/1ps
`default_nettype none
`include "spc_cfg.svh"
module spc_assertions (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CMD_START,
  input wire logic [7:0] CMD,
  input wire spc_pkg::spc_rx_t RX,
  input wire logic TX_READY,
  input wire spc_pkg::spc_tx_t TX,
  input wire spc_pkg::spc_wr_t WR,
  input wire spc_pkg::spc_mem_t MEM,
  input wire logic BUSY,
  input wire logic LOCKED
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // A sum or RAM-load command taken while ready; other codes go their own way
  sequence s_taken;
    CMD_START && !BUSY && !LOCKED && (CMD == `SPC_CMD_SUM || CMD == `SPC_CMD_RAM);
  endsequence
  // The last reply byte taken just before
  sequence s_accepted;
    $past(TX.valid && TX_READY);
  endsequence
  a_cmd_busy: assert property (s_taken |=> BUSY)
    else $error("command not started");
  a_sweep_step: assert property (MEM.rd && $past(MEM.rd) |->
    MEM.addr == $past(MEM.addr) + 16'h0001)
    else $error("sweep skipped an address");
  a_sweep_flash: assert property (MEM.rd |-> MEM.addr >= `SPC_FLASH_LO)
    else $error("sweep left the flash range");
  a_busy_end: assert property ($fell(BUSY) && !LOCKED |-> s_accepted)
    else $error("command ended without reply");
  a_reply_hold: assert property (TX.valid && !TX_READY |=> TX.valid && $stable(TX.data))
    else $error("reply byte changed before taken");
  a_wr_payload: assert property (WR.valid |->
    $past(RX.valid) && WR.data == $past(RX.data))
    else $error("write byte not a payload byte");
  a_wr_step: assert property (WR.valid && $past(WR.valid) |->
    WR.addr == $past(WR.addr) + 20'h0_0001)
    else $error("payload address did not step");
  a_wr_busy: assert property (WR.valid |-> BUSY)
    else $error("write outside a command");
  a_lock_holds: assert property (LOCKED |=> LOCKED)
    else $error("left idle without reset");
  a_lock_quiet: assert property (LOCKED |-> !TX.valid && !WR.valid && !MEM.rd)
    else $error("activity while idle");
endmodule
bind spc_record_sum spc_assertions u_chk (.CLK(CLK), .RESETN(RESETN), .CMD_START(CMD_START),
  .CMD(CMD), .RX(RX), .TX_READY(TX_READY), .TX(TX), .WR(WR), .MEM(MEM), .BUSY(BUSY),
  .LOCKED(LOCKED));
`default_nettype wire

// [tb/spc_far_model.sv]
// Far side model: flash array read port and a reply taker that stalls
`timescale 1ns/1ps
`default_nettype none
module spc_far_model (
  input wire logic CLK,
  input wire logic RESETN,
  input wire spc_pkg::spc_mem_t MEM,
  output logic [7:0] MEM_RDATA,
  output logic TX_READY
);
  logic [1:0] ph;
  // Data one cycle after a read; otherwise flipped so a late sample misses
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      MEM_RDATA <= 8'h00;
      ph <= 2'h0;
      TX_READY <= 1'b0;
    end
    else
    begin
      MEM_RDATA <= MEM.rd ? (MEM.addr[7:0] ^ MEM.addr[15:8] ^ 8'h5A) : ~MEM_RDATA;
      ph <= ph + 2'h1;
      TX_READY <= (ph != 2'h2); // Stall one cycle in four to test holding
    end
endmodule
`default_nettype wire

// [tb/tb_serial_prog_record_checksum.sv]
// Self-checking bench for the record parser and checksum block
`timescale 1ns/1ps
`default_nettype none
module tb_serial_prog_record_checksum;
  logic CLK, RESETN, CMD_START, OVERWRITE, TX_READY, BUSY, LOCKED;
  logic [7:0] CMD, MEM_RDATA, b, ov;
  logic [15:0] RANGE_LO, RANGE_HI;
  spc_pkg::spc_rx_t RX;
  spc_pkg::spc_xfer_t XFER;
  spc_pkg::spc_tx_t TX;
  spc_pkg::spc_wr_t WR;
  spc_pkg::spc_mem_t MEM;
  int n_mismatch, n_tests, wr_n, tx_n, rs;
  logic [31:0] seed;
  logic [19:0] wr_last;
  logic wr_ram;
  logic [7:0] q[$];
  logic [7:0] ex[$];
  spc_record_sum DUT (.CLK(CLK), .RESETN(RESETN), .CMD_START(CMD_START), .CMD(CMD),
    .RANGE_LO(RANGE_LO), .RANGE_HI(RANGE_HI), .OVERWRITE(OVERWRITE), .RX(RX), .XFER(XFER),
    .MEM_RDATA(MEM_RDATA), .TX_READY(TX_READY), .TX(TX), .WR(WR), .MEM(MEM), .BUSY(BUSY),
    .LOCKED(LOCKED));
  spc_far_model FAR (.CLK(CLK), .RESETN(RESETN), .MEM(MEM), .MEM_RDATA(MEM_RDATA),
    .TX_READY(TX_READY));
  // Free-running system clock
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // Tally writer pulses and any reply traffic
  always @(negedge CLK)
  begin
    if (WR.valid === 1'b1)
    begin
      wr_n++;
      wr_last = WR.addr;
      wr_ram = WR.ram;
    end
    if (TX.valid === 1'b1)
      tx_n++;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Reference sum over the far-side flash contents
  function automatic int fsum(input int lo, input int hi);
    int s;
    s = 0;
    for (int a = lo; a <= hi; a++)
      s += (a & 255) ^ ((a >> 8) & 255) ^ 8'h5A;
    return s;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rst();
    // Reset lands on a rising edge like every other input
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    wr_n = 0;
    tx_n = 0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] lo, input logic [15:0] hi);
    @(posedge CLK);
    CMD_START <= 1'b1;
    CMD <= c;
    RANGE_LO <= lo;
    RANGE_HI <= hi;
    @(posedge CLK);
    CMD_START <= 1'b0;
  endtask
  // One received byte per edge; back to back unless rx_end drops valid
  task automatic rx(input logic [7:0] d, input logic [1:0] e);
    @(posedge CLK);
    RX <= {1'b1, d, e};
  endtask
  task automatic rx_end();
    @(posedge CLK);
    RX <= 11'h000;
  endtask
  // Whole record from q; bad is added to the checksum byte
  task automatic rec(input logic [7:0] len, input logic [15:0] ofs, input logic [7:0] typ,
    input logic [7:0] bad);
    logic [7:0] s;
    s = len + ofs[15:8] + ofs[7:0] + typ;
    rx(8'h3A, 2'h0);
    rx(len, 2'h0);
    rx(ofs[15:8], 2'h0);
    rx(ofs[7:0], 2'h0);
    rx(typ, 2'h0);
    foreach (q[i])
    begin
      rx(q[i], 2'h0);
      s += q[i];
    end
    rx(8'h00 - s + bad, 2'h0);
    q = {};
  endtask
  task automatic sum2(input int s);
    ex.push_back(s[15:8]);
    ex.push_back(s[7:0]);
  endtask
  // Reply bytes compared as the far side takes them, then the end state
  task automatic reply(input logic [1:0] lk);
    int t;
    foreach (ex[i])
    begin
      t = 0;
      do
      begin
        @(negedge CLK);
        t++;
      end
      while (!(TX.valid === 1'b1 && TX_READY === 1'b1) && t < 40000);
      if (t >= 40000)
      begin
        n_mismatch++;
        $display("Error at %0t: no reply, got %h expected %h", $time, 8'h00, ex[i]);
        complete_run();
      end
      chk(TX.data, ex[i]);
    end
    @(negedge CLK);
    chk({14'h0000, BUSY, LOCKED}, {14'h0000, lk});
    ex = {};
  endtask
  initial
  begin
    seed = 32'h0000_5DD0;
    n_mismatch = 0;
    n_tests = 0;
    RESETN = 1'b0;
    CMD_START = 1'b0;
    CMD = 8'h00;
    RANGE_LO = 16'h0000;
    RANGE_HI = 16'h0000;
    OVERWRITE = 1'b0;
    RX = 11'h000;
    XFER = 9'h000;
    rst();
    // Sweeps: whole array, top-boundary read, small erase
    cmd(8'h90, 16'h0000, 16'h0000);
    sum2(fsum(32'h0000_8000, 32'h0000_FFFF));
    reply(2'h0);
    cmd(8'h40, 16'hFFF0, 16'hFFFF);
    sum2(fsum(32'h0000_FFF0, 32'h0000_FFFF));
    reply(2'h0);
    cmd(8'hF0, 16'h8000, 16'h8003);
    sum2(fsum(32'h0000_8000, 32'h0000_8003));
    reply(2'h0);
    $display("test sweeps done");
    // RAM load: noise before and between records, under segment one
    cmd(8'h60, 16'h0000, 16'h0000);
    rx(8'h55, 2'h0);
    q = {8'h00, 8'h01};
    rec(8'h02, 16'h0000, 8'h02, 8'h00);
    rs = 0;
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        q.push_back(rnd());
        rs += q[i];
      end
      rec(8'h04, 16'h0010 + 16'(r * 4), 8'h00, 8'h00);
      rx(8'h3B, 2'h0);
    end
    rec(8'h00, 16'h0000, 8'h01, 8'h00);
    rx_end();
    sum2(rs);
    reply(2'h0);
    chk(16'(wr_n), 16'h0008);
    chk(wr_last[15:0], 16'h0027);
    chk({15'h0000, wr_ram}, 16'h0001);
    $display("test ram load done");
    // Partial flash write still returns the whole-array sum
    ov = rnd();
    @(posedge CLK);
    OVERWRITE <= ov[0];
    wr_n = 0;
    cmd(8'h30, 16'h0000, 16'h0000);
    q = {rnd(), rnd()};
    rec(8'h02, 16'h0100, 8'h00, 8'h00);
    rec(8'h00, 16'h0000, 8'h01, 8'h00);
    rx_end();
    ex.push_back({7'h00, ov[0]});
    sum2(fsum(32'h0000_8000, 32'h0000_FFFF));
    reply(2'h0);
    chk(16'(wr_n), 16'h0002);
    chk(wr_last[15:0], 16'h0101);
    chk({15'h0000, wr_ram}, 16'h0000);
    $display("test write done");
    // Identity and status: only transferred bytes from the ninth to the last count
    for (int k = 0; k < 2; k++)
    begin
      cmd(k ? 8'hC3 : 8'hC0, 16'h0000, 16'h0000);
      rs = 0;
      for (int i = 1; i <= (k ? 12 : 18); i++)
      begin
        b = rnd();
        @(posedge CLK);
        XFER <= {1'b1, b};
        if (i >= 9)
          rs += b;
        @(posedge CLK);
        XFER <= 9'h000;
      end
      sum2(rs);
      reply(2'h0);
    end
    $display("test transfer sums done");
    // Each error from a fresh reset: silent lock, or a code sent thrice
    for (int k = 0; k < 9; k++)
    begin
      rst();
      q = {8'h00, 8'h00};
      if (k < 6)
        cmd(8'h60, 16'h0000, 16'h0000);
      case (k)
        0: rec(8'h02, 16'h0000, 8'h03, 8'h00);
        1: rec(8'h02, 16'h0000, 8'h00, 8'h01);
        2:
        begin
          q.push_back(8'h00);
          rec(8'h03, 16'h0000, 8'h02, 8'h00);
        end
        3: rec(8'h02, 16'h0001, 8'h02, 8'h00);
        4:
        begin
          q = {8'h20, 8'h01};
          rec(8'h02, 16'h0000, 8'h02, 8'h00);
          q = {8'h11};
          rec(8'h01, 16'h0000, 8'h00, 8'h00);
        end
        5:
        begin
          q = {8'h00};
          rec(8'h01, 16'h0000, 8'h01, 8'h00);
        end
        6: rx(8'h00, 2'h3);
        7: rx(8'h00, 2'h1);
        default: cmd(8'h77, 16'h0000, 16'h0000);
      endcase
      rx_end();
      if (k < 6)
      begin
        repeat (6) @(negedge CLK);
        chk({15'h0000, LOCKED}, 16'h0001);
        chk(16'(tx_n), 16'h0000);
      end
      else
      begin
        for (int j = 0; j < 3; j++)
          ex.push_back(k == 6 ? 8'hA1 : (k == 7 ? 8'hA3 : 8'h63));
        reply(2'h1);
      end
      $display("test error case %0d done", k);
    end
    complete_run();
  end
endmodule
`default_nettype wire
